//--- pbc_top.sv
// Base clock selector with PLL control registers behind an APB slave.
//
// Overview of operation
// - Selected clock passes switch, then divide by two.
// - Source change waits three edges each, output frozen.
// - Refuse VCO select while PLL is off.
// - Refuse PLL off while VCO selected.
// - Interlocks judged against held values, separate writes.
// - Zero linear range disables PLL, forces oscillator.
// - PLL settings writable only while PLL off.
// - Lock interrupt enable gates lock-change requests.
// - Enable ignored and reads zero in manual mode.
// - Reset clears lock interrupt enable.
// - Interrupt output ORs lock-change request with masked event status.
// - Reference clock buffers the oscillator clock.
// - Flag sets on toggle in auto mode, read clears, manual reads zero.
// - Reset turns PLL on, selects oscillator.
`default_nettype none
module pbc_top
(
  input wire logic clk, // System clock, 200 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic osc_clock, // Oscillator clock pin.
  input wire logic divided_vco_clock, // Divided VCO clock pin.
  input wire logic lock_pin, // Lock detector level from the analog loop.
  input wire logic acq_pin, // Tracking indicator from the analog loop.
  output logic base_clock_out, // Base clock to system integration.
  output logic pll_reference_clock, // Reference clock to the PLL.
  output logic clockgen_irq, // Interrupt, active high level.
  output pbc_pkg::pbc_pll_cfg_t pll_cfg // Effective PLL settings.
);
  import pbc_pkg::*;

  function automatic logic [11:0] fix_zero(input logic [11:0] v);
    fix_zero = (v == 12'h000) ? PBC_ONE12 : v;
  endfunction : fix_zero

  ////////////////////////////////////////////////////////////////////////////////
  logic [PBC_SY_W-1:0] sy;
  logic lock_q;
  logic lock_toggle;
  pbc_ctrl_t ctrl;
  logic bw_auto;
  logic acq_manual;
  logic [11:0] mul;
  logic [7:0] lin;
  logic [3:0] rdiv;
  logic [PBC_EV_W-1:0] irq_stat;
  logic [PBC_EV_W-1:0] irq_mask;
  logic switch_done;
  logic access;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [7:0] wd;
  logic [31:0] next_prdata;
  logic ctrl_read;
  logic lin_zero;

  pbc_sync u_sync
  (
    .clk(clk),
    .rst_n(rst_n),
    .d({acq_pin, lock_pin, divided_vco_clock, osc_clock}),
    .q(sy)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, so read data and ready come from flops.
  assign access = psel & penable;
  assign wr_en = access & pready & pwrite;
  assign rd_en = access & pready & ~pwrite;
  assign wd = pwdata[7:0];
  assign ctrl_read = rd_en && paddr == PBC_ADDR_CTRL;
  assign lin_zero = (lin == 8'h00);

  always_comb
  begin
    addr_ok = 1'b1;
    next_prdata = 32'h0000_0000;
    case (paddr)
      PBC_ADDR_CTRL:
      begin
        next_prdata[PBC_CTRL_IE] = ctrl.irq_en & bw_auto;
        next_prdata[PBC_CTRL_FLAG] = ctrl.flag & bw_auto;
        next_prdata[PBC_CTRL_ON] = ctrl.pll_on;
        next_prdata[PBC_CTRL_BCS] = ctrl.base_clock_select;
        next_prdata[PBC_CTRL_PRE_LO +: 2] = ctrl.pre;
        next_prdata[PBC_CTRL_VPR_LO +: 2] = ctrl.vco_range_exponent;
      end
      PBC_ADDR_BW:
      begin
        next_prdata[PBC_BW_AUTO] = bw_auto;
        next_prdata[PBC_BW_LOCK] = bw_auto & sy[PBC_SY_LOCK];
        next_prdata[PBC_BW_ACQ] = bw_auto ? sy[PBC_SY_ACQ] : acq_manual;
      end
      PBC_ADDR_MUL_LO: next_prdata[7:0] = mul[7:0];
      PBC_ADDR_MUL_HI: next_prdata[3:0] = mul[11:PBC_MUL_HI_LO];
      PBC_ADDR_RANGE: next_prdata[7:0] = lin;
      PBC_ADDR_RDIV: next_prdata[3:0] = rdiv;
      PBC_ADDR_IRQ_STAT: next_prdata[PBC_EV_W-1:0] = irq_stat;
      PBC_ADDR_IRQ_MASK: next_prdata[PBC_EV_W-1:0] = irq_mask;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~addr_ok;
      prdata <= (access & ~pready & ~pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control register with power and source interlocks on the held values.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl.irq_en <= PBC_CTRL_RESET.irq_en;
      ctrl.pll_on <= PBC_CTRL_RESET.pll_on;
      ctrl.base_clock_select <= PBC_CTRL_RESET.base_clock_select;
      ctrl.pre <= PBC_CTRL_RESET.pre;
      ctrl.vco_range_exponent <= PBC_CTRL_RESET.vco_range_exponent;
    end
    else
    begin
      if (wr_en && paddr == PBC_ADDR_CTRL)
      begin
        if (bw_auto)
        begin
          ctrl.irq_en <= wd[PBC_CTRL_IE];
        end
        if (wd[PBC_CTRL_ON] || !ctrl.base_clock_select)
        begin
          ctrl.pll_on <= wd[PBC_CTRL_ON];
        end
        if (!wd[PBC_CTRL_BCS] || (ctrl.pll_on && !lin_zero))
        begin
          ctrl.base_clock_select <= wd[PBC_CTRL_BCS];
        end
        if (!ctrl.pll_on)
        begin
          ctrl.pre <= wd[PBC_CTRL_PRE_LO +: 2];
          ctrl.vco_range_exponent <= wd[PBC_CTRL_VPR_LO +: 2];
        end
      end
      if (lin_zero)
      begin
        ctrl.base_clock_select <= 1'b0;
      end
    end
  end

  // Lock-change flag: a toggle in the same cycle as a clearing read wins.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_q <= 1'b0;
      ctrl.flag <= PBC_CTRL_RESET.flag;
    end
    else
    begin
      lock_q <= sy[PBC_SY_LOCK];
      if (lock_toggle && bw_auto)
      begin
        ctrl.flag <= 1'b1;
      end
      else if (ctrl_read)
      begin
        ctrl.flag <= 1'b0;
      end
    end
  end

  assign lock_toggle = sy[PBC_SY_LOCK] ^ lock_q;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bw_auto <= 1'b0;
      acq_manual <= 1'b0;
    end
    else if (wr_en && paddr == PBC_ADDR_BW)
    begin
      bw_auto <= wd[PBC_BW_AUTO];
      if (!bw_auto)
      begin
        acq_manual <= wd[PBC_BW_ACQ];
      end
    end
  end

  // Loop settings only change while the PLL is off.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mul <= PBC_MUL_RESET;
      lin <= PBC_RANGE_RESET;
      rdiv <= PBC_RDIV_RESET;
    end
    else if (wr_en && !ctrl.pll_on)
    begin
      case (paddr)
        PBC_ADDR_MUL_LO: mul[7:0] <= wd;
        PBC_ADDR_MUL_HI: mul[11:PBC_MUL_HI_LO] <= wd[3:0];
        PBC_ADDR_RANGE: lin <= wd;
        PBC_ADDR_RDIV: rdiv <= wd[3:0];
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pll_cfg <= '0;
    end
    else
    begin
      pll_cfg.enable <= ctrl.pll_on & ~lin_zero;
      pll_cfg.acq <= bw_auto ? sy[PBC_SY_ACQ] : acq_manual;
      pll_cfg.pre <= ctrl.pre;
      pll_cfg.vco_range_exponent <= ctrl.vco_range_exponent;
      pll_cfg.mul <= fix_zero(mul);
      pll_cfg.lin <= lin;
      pll_cfg.rdiv <= 4'(fix_zero({8'h00, rdiv}));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky event status, write one to clear, with set winning.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat <= '0;
      irq_mask <= '0;
    end
    else
    begin
      for (int i = 0; i < PBC_EV_W; i++)
      begin
        if ((i == PBC_EV_LOCK && lock_toggle && bw_auto) || (i == PBC_EV_SWITCH && switch_done))
        begin
          irq_stat[i] <= 1'b1;
        end
        else if (wr_en && paddr == PBC_ADDR_IRQ_STAT && wd[i])
        begin
          irq_stat[i] <= 1'b0;
        end
      end
      if (wr_en && paddr == PBC_ADDR_IRQ_MASK)
      begin
        irq_mask <= wd[PBC_EV_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clockgen_irq <= 1'b0;
    end
    else
    begin
      clockgen_irq <= (ctrl.flag & ctrl.irq_en & bw_auto)
                      | (|(irq_stat & irq_mask));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  pbc_clock_switch u_switch
  (
    .clk(clk),
    .rst_n(rst_n),
    .osc_level(sy[PBC_SY_OSC]),
    .vco_level(sy[PBC_SY_VCO]),
    .select_vco(ctrl.base_clock_select),
    .base_clock_out(base_clock_out),
    .pll_reference_clock(pll_reference_clock),
    .switch_done(switch_done)
  );

endmodule : pbc_top
`default_nettype wire

//--- pbc_pkg.sv
// Package with register map, field layout, reset values and carrier types of the base clock block.
`default_nettype none
package pbc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] PBC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] PBC_ADDR_BW = 8'h04;
  localparam logic [7:0] PBC_ADDR_MUL_LO = 8'h08;
  localparam logic [7:0] PBC_ADDR_MUL_HI = 8'h0C;
  localparam logic [7:0] PBC_ADDR_RANGE = 8'h10;
  localparam logic [7:0] PBC_ADDR_RDIV = 8'h14;
  localparam logic [7:0] PBC_ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] PBC_ADDR_IRQ_MASK = 8'h1C;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int PBC_CTRL_IE = 7;
  localparam int PBC_CTRL_FLAG = 6;
  localparam int PBC_CTRL_ON = 5;
  localparam int PBC_CTRL_BCS = 4;
  localparam int PBC_CTRL_PRE_LO = 2;
  localparam int PBC_CTRL_VPR_LO = 0;
  localparam int PBC_BW_AUTO = 7;
  localparam int PBC_BW_LOCK = 6;
  localparam int PBC_BW_ACQ = 5;
  localparam int PBC_MUL_HI_LO = 8;

  localparam int PBC_EV_LOCK = 0;
  localparam int PBC_EV_SWITCH = 1;
  localparam int PBC_EV_W = 2;

  localparam int PBC_SY_OSC = 0;
  localparam int PBC_SY_VCO = 1;
  localparam int PBC_SY_LOCK = 2;
  localparam int PBC_SY_ACQ = 3;
  localparam int PBC_SY_W = 4;

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [11:0] PBC_MUL_RESET = 12'h040;
  localparam logic [7:0] PBC_RANGE_RESET = 8'h40;
  localparam logic [3:0] PBC_RDIV_RESET = 4'h1;
  localparam logic [11:0] PBC_ONE12 = 12'h001;
  localparam logic [1:0] PBC_SWITCH_EDGES = 2'h3;

  typedef struct packed {
    logic irq_en;
    logic flag;
    logic pll_on;
    logic base_clock_select;
    logic [1:0] pre;
    logic [1:0] vco_range_exponent;
  } pbc_ctrl_t;

  localparam pbc_ctrl_t PBC_CTRL_RESET = '{irq_en: 1'b0, flag: 1'b0, pll_on: 1'b1,
                                           base_clock_select: 1'b0, pre: 2'h0, vco_range_exponent: 2'h0};

  typedef struct packed {
    logic enable;
    logic acq;
    logic [1:0] pre;
    logic [1:0] vco_range_exponent;
    logic [11:0] mul;
    logic [7:0] lin;
    logic [3:0] rdiv;
  } pbc_pll_cfg_t;

  typedef enum logic [2:0] {
    PBC_SW_RUN = 3'b001,
    PBC_SW_OLD = 3'b010,
    PBC_SW_NEW = 3'b100
  } pbc_sw_state_t;

endpackage : pbc_pkg
`default_nettype wire

//--- pbc_sync.sv
// Two-flop synchroniser for pins and foreign clocks.
`default_nettype none
module pbc_sync
(
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [pbc_pkg::PBC_SY_W-1:0] d, // Asynchronous levels.
  output logic [pbc_pkg::PBC_SY_W-1:0] q // Synchronised levels.
);
  import pbc_pkg::*;

  logic [PBC_SY_W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : pbc_sync
`default_nettype wire

//--- pbc_clock_switch.sv
// Glitch-free source switch with divide-by-two stage and reference clock copy.
`default_nettype none
module pbc_clock_switch
(
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic osc_level, // Synchronised oscillator clock level.
  input wire logic vco_level, // Synchronised divided VCO clock level.
  input wire logic select_vco, // Requested source, 1 picks the divided VCO clock.
  output logic base_clock_out, // Selected source divided by two.
  output logic pll_reference_clock, // Buffered oscillator clock.
  output logic switch_done // One-cycle pulse when a source change completes.
);
  import pbc_pkg::*;

  logic osc_q;
  logic vco_q;
  logic osc_rise;
  logic vco_rise;
  logic cur_sel;
  logic [1:0] edge_cnt;
  pbc_sw_state_t state;
  logic old_rise;
  logic new_rise;
  logic cur_rise;

  assign osc_rise = osc_level & ~osc_q;
  assign vco_rise = vco_level & ~vco_q;
  assign cur_rise = cur_sel ? vco_rise : osc_rise;
  assign old_rise = cur_rise;
  assign new_rise = cur_sel ? osc_rise : vco_rise;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_q <= 1'b0;
      vco_q <= 1'b0;
      pll_reference_clock <= 1'b0;
    end
    else
    begin
      osc_q <= osc_level;
      vco_q <= vco_level;
      pll_reference_clock <= osc_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Waits three edges of the old source, then three of the new, output frozen.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= PBC_SW_RUN;
      edge_cnt <= 2'h0;
      cur_sel <= 1'b0;
      switch_done <= 1'b0;
    end
    else
    begin
      switch_done <= 1'b0;
      case (state)
        PBC_SW_RUN:
        begin
          if (select_vco != cur_sel)
          begin
            state <= PBC_SW_OLD;
            edge_cnt <= 2'h0;
          end
        end
        PBC_SW_OLD:
        begin
          if (old_rise)
          begin
            if (edge_cnt == PBC_SWITCH_EDGES - 2'h1)
            begin
              state <= PBC_SW_NEW;
              edge_cnt <= 2'h0;
            end
            else
            begin
              edge_cnt <= edge_cnt + 2'h1;
            end
          end
        end
        PBC_SW_NEW:
        begin
          if (new_rise)
          begin
            if (edge_cnt == PBC_SWITCH_EDGES - 2'h1)
            begin
              state <= PBC_SW_RUN;
              cur_sel <= ~cur_sel;
              switch_done <= 1'b1;
            end
            else
            begin
              edge_cnt <= edge_cnt + 2'h1;
            end
          end
        end
        default:
        begin
          state <= PBC_SW_RUN;
        end
      endcase
    end
  end

  // Toggling on each source rising edge gives an even duty cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base_clock_out <= 1'b0;
    end
    else if (state == PBC_SW_RUN && cur_rise)
    begin
      base_clock_out <= ~base_clock_out;
    end
  end

endmodule : pbc_clock_switch
`default_nettype wire

//--- pbc_properties.sv
// Checker of the base clock block, bound to its top module.
`default_nettype none
module pbc_properties
(
  input wire logic clk, // System clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB write.
  input wire logic [7:0] paddr, // APB address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [31:0] prdata, // APB read data.
  input wire logic pready, // APB ready.
  input wire logic osc_clock, // Oscillator clock.
  input wire logic base_clock_out, // Base clock.
  input wire logic pll_reference_clock, // Reference clock.
  input wire pbc_pkg::pbc_pll_cfg_t pll_cfg // Effective settings.
);
  timeunit 1ns;
  timeprecision 100ps;
  import pbc_pkg::*;
  logic [3:0] up;
  logic auto_q;
  logic done;
  assign done = psel && penable && pready;
  // Counts edges since reset so that history from before it is never judged.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      up <= 4'h0;
    else if (up != 4'hF)
      up <= up + 4'h1;
  end
  // Mirrors the bandwidth mode from completed writes.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      auto_q <= 1'b0;
    else if (done && pwrite && paddr == PBC_ADDR_BW)
      auto_q <= pwdata[PBC_BW_AUTO];
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  AST_APB_WAIT: assert property (s_setup |=> s_answer)
    else $error("APB answer not after one wait state");
  AST_REF_COPY: assert property (up > 4'h4 |-> pll_reference_clock == $past(osc_clock, 3))
    else $error("Reference clock is not the delayed oscillator");
  AST_BASE_HALF: assert property ($changed(base_clock_out) |=> $stable(base_clock_out)[*3])
    else $error("Base clock toggled too soon");
  AST_ZERO_ONE: assert property (up != 4'h0 |-> pll_cfg.mul != 12'h000 && pll_cfg.rdiv != 4'h0)
    else $error("Zero divider or multiplier reached the loop");
  AST_LIN_OFF: assert property (pll_cfg.lin == 8'h00 |-> !pll_cfg.enable)
    else $error("Loop enabled with zero range");
  AST_CFG_HOLD: assert property (pll_cfg.enable && $past(pll_cfg.enable) |->
    $stable({pll_cfg.pre, pll_cfg.vco_range_exponent, pll_cfg.mul, pll_cfg.lin, pll_cfg.rdiv}))
    else $error("Loop settings changed while on");
  AST_IE_MANUAL: assert property (done && !pwrite && paddr == PBC_ADDR_CTRL && !auto_q |->
    prdata[7:6] == 2'b00)
    else $error("Enable or flag read nonzero in manual mode");
  AST_RESET_CFG: assert property (up == 4'h1 |-> pll_cfg.enable && pll_cfg.lin == 8'h40
    && pll_cfg.mul == 12'h040 && pll_cfg.rdiv == 4'h1)
    else $error("Settings after reset wrong");
endmodule : pbc_properties
bind pbc_top pbc_properties pbc_properties_inst (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .osc_clock, .base_clock_out, .pll_reference_clock, .pll_cfg);
`default_nettype wire

//--- pbc_sim_model.sv
// Clock sources and base clock consumer around the base clock block.
`default_nettype none
module pbc_sim_model
#(
  parameter int OSC_HALF = 20,
  parameter int VCO_HALF = 30
)
(
  output logic osc_clock, // Oscillator clock.
  output logic divided_vco_clock, // Divided VCO clock.
  input wire logic base_clock_out, // Base clock from the block.
  output var int toggles // Base clock edges seen.
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    osc_clock = 1'b0;
    divided_vco_clock = 1'b0;
    toggles = 0;
  end
  always #(OSC_HALF) osc_clock = ~osc_clock;
  always #(VCO_HALF) divided_vco_clock = ~divided_vco_clock;
  always @(base_clock_out) toggles = toggles + 1;
endmodule : pbc_sim_model
`default_nettype wire

//--- pbc_top_test.sv
// Self-checking bench of the base clock block with APB driver and read scoreboard.
`default_nettype none
module pbc_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import pbc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic lock_pin = 1'b0;
  logic acq_pin = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, osc_clock, divided_vco_clock, base_clock_out;
  logic pll_reference_clock, clockgen_irq;
  pbc_pll_cfg_t pll_cfg;
  int toggles;
  int failures = 0;
  int comparisons = 0;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [11:0] n;
  logic [3:0] r;
  always #2.5 clk = ~clk;
  pbc_top pbc_top_inst (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .osc_clock, .divided_vco_clock, .lock_pin, .acq_pin, .base_clock_out,
    .pll_reference_clock, .clockgen_irq, .pll_cfg);
  pbc_sim_model pbc_sim_model_inst (.osc_clock, .divided_vco_clock, .base_clock_out, .toggles);
  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
    int k;
    exp_q.push_back({w, err, d});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0000_0000;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        return;
    end
    failures++;
    $display("Error at %0t: no ready", $time);
    stop_test();
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d}, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    apb(1'b0, a, {24'h00_0000, d}, 1'b0);
  endtask : rd
  task automatic cyc(input int c);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (c) @(posedge clk);
  endtask : cyc
  task automatic wait_irq();
    int k;
    cyc(1);
    for (k = 0; clockgen_irq !== 1'b1; k++)
    begin
      if (k == 400)
      begin
        failures++;
        $display("Error at %0t: no interrupt", $time);
        stop_test();
      end
      @(posedge clk);
    end
  endtask : wait_irq
  task automatic rate(input int lo, input int hi);
    int t0;
    t0 = toggles;
    cyc(240);
    check({31'h0000_0000, toggles - t0 >= lo && toggles - t0 <= hi}, 32'h0000_0001);
  endtask : rate
  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : reset_dut
  // Scoreboard: every completed transfer takes the oldest expectation.
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1)
    begin
      e = exp_q.pop_front();
      check({31'h0000_0000, pslverr}, {31'h0000_0000, e[32]});
      if (!e[33])
        check(prdata, e[31:0]);
    end
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(63));
    reset_dut();
    rd(PBC_ADDR_CTRL, 8'h20);
    rd(PBC_ADDR_BW, 8'h00);
    rd(PBC_ADDR_MUL_LO, 8'h40);
    rd(PBC_ADDR_RANGE, 8'h40);
    rd(PBC_ADDR_RDIV, 8'h01);
    apb(1'b0, 8'h20, 32'h0000_0000, 1'b1);
    wr(PBC_ADDR_RDIV, 8'h05);
    wr(PBC_ADDR_CTRL, 8'h2F);
    rd(PBC_ADDR_RDIV, 8'h01);
    rd(PBC_ADDR_CTRL, 8'h20);
    wr(PBC_ADDR_CTRL, 8'h00);
    wr(PBC_ADDR_CTRL, 8'h10);
    rd(PBC_ADDR_CTRL, 8'h00);
    wr(PBC_ADDR_CTRL, 8'h30);
    rd(PBC_ADDR_CTRL, 8'h20);
    wr(PBC_ADDR_CTRL, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      n = (i == 0) ? 12'h000 : 12'($urandom());
      r = (i == 0) ? 4'h0 : 4'($urandom());
      wr(PBC_ADDR_MUL_LO, n[7:0]);
      wr(PBC_ADDR_MUL_HI, {4'h0, n[11:8]});
      wr(PBC_ADDR_RDIV, {4'h0, r});
      rd(PBC_ADDR_MUL_LO, n[7:0]);
      rd(PBC_ADDR_RDIV, {4'h0, r});
      cyc(2);
      check(32'(pll_cfg.mul), 32'(n == 12'h000 ? 12'h001 : n));
      check(32'(pll_cfg.rdiv), 32'(r == 4'h0 ? 4'h1 : r));
    end
    wr(PBC_ADDR_RANGE, 8'h00);
    wr(PBC_ADDR_CTRL, 8'h20);
    wr(PBC_ADDR_CTRL, 8'h30);
    rd(PBC_ADDR_CTRL, 8'h20);
    check(32'(pll_cfg.enable), 32'h0000_0000);
    wr(PBC_ADDR_CTRL, 8'h00);
    wr(PBC_ADDR_RANGE, 8'h40);
    wr(PBC_ADDR_CTRL, 8'h20);
    rate(29, 31);
    wr(PBC_ADDR_IRQ_MASK, 8'h02);
    wr(PBC_ADDR_CTRL, 8'h30);
    cyc(2);
    n = 12'(toggles);
    wait_irq();
    check(32'(toggles), 32'(n));
    rd(PBC_ADDR_IRQ_STAT, 8'h02);
    wr(PBC_ADDR_IRQ_STAT, 8'h02);
    rd(PBC_ADDR_IRQ_STAT, 8'h00);
    check(32'(clockgen_irq), 32'h0000_0000);
    wr(PBC_ADDR_CTRL, 8'h10);
    rd(PBC_ADDR_CTRL, 8'h30);
    rate(19, 21);
    wr(PBC_ADDR_CTRL, 8'h20);
    wait_irq();
    wr(PBC_ADDR_IRQ_STAT, 8'h02);
    wr(PBC_ADDR_CTRL, 8'hA0);
    rd(PBC_ADDR_CTRL, 8'h20);
    lock_pin <= 1'b1;
    cyc(6);
    check(32'(clockgen_irq), 32'h0000_0000);
    rd(PBC_ADDR_CTRL, 8'h20);
    wr(PBC_ADDR_BW, 8'h80);
    wr(PBC_ADDR_CTRL, 8'hA0);
    rd(PBC_ADDR_CTRL, 8'hA0);
    lock_pin <= 1'b0;
    cyc(6);
    check(32'(clockgen_irq), 32'h0000_0001);
    rd(PBC_ADDR_BW, 8'h80);
    rd(PBC_ADDR_CTRL, 8'hE0);
    cyc(2);
    check(32'(clockgen_irq), 32'h0000_0000);
    rd(PBC_ADDR_CTRL, 8'hA0);
    wr(PBC_ADDR_CTRL, 8'h20);
    lock_pin <= 1'b1;
    cyc(6);
    check(32'(clockgen_irq), 32'h0000_0000);
    rd(PBC_ADDR_BW, 8'hC0);
    rd(PBC_ADDR_CTRL, 8'h60);
    cyc(1);
    reset_dut();
    rd(PBC_ADDR_CTRL, 8'h20);
    rd(PBC_ADDR_BW, 8'h00);
    cyc(2);
    stop_test();
  end
endmodule : pbc_top_test
`default_nettype wire
